/* File: dacrb_pkg.sv */
// constants for the dac control register bank
package dacrb_pkg;
    localparam int DACRB_DW = 8;
    localparam int DACRB_AW = 5;
    localparam logic [4:0] DACRB_ADDR_MAIN = 5'h00;
    localparam logic [4:0] DACRB_ADDR_OUT = 5'h01;
    localparam logic [4:0] DACRB_ADDR_TUNE = 5'h02;
    localparam logic [4:0] DACRB_ADDR_LAST = DACRB_ADDR_TUNE;
    localparam logic [7:0] DACRB_RST_VAL = 8'h00;
    // main_control fields
    localparam int DACRB_MUTE_REL_BIT = 0;
    localparam int DACRB_STANDBY_BIT = 1;
    localparam int DACRB_RSEL_BIT = 2;
    localparam int DACRB_LSEL_BIT = 3;
    localparam int DACRB_STEREO_BIT = 4;
    localparam int DACRB_RATE_BIT = 5;
    localparam int DACRB_THRESH_BIT = 6;
    localparam int DACRB_CSTOP_BIT = 7;
    // output_control fields
    localparam int DACRB_RIGHT_INV_BIT = 0;
    localparam int DACRB_LEFT_INV_BIT = 1;
    localparam int DACRB_TUNE_HI_BIT = 6;
    localparam int DACRB_PROFILE_BIT = 7;
    // tuning_test_control fields
    localparam int DACRB_TEST_BIT = 0;
    localparam int DACRB_TUNE_LO_LSB = 4;
    localparam int DACRB_TUNE_LO_W = 4;
    typedef enum logic [1:0] {
        DACRB_ACC_IDLE,
        DACRB_ACC_ADDR,
        DACRB_ACC_DATA
    } dacrb_acc_t;
endpackage

/* File: dacrb_addr_counter.sv */
// register address counter with wrap past the last register
`timescale 1ns/1ps
module dacrb_addr_counter
    import dacrb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [DACRB_AW-1:0] i_load_addr,
    input wire logic i_advance,
    output logic [DACRB_AW-1:0] o_addr
);
    logic [DACRB_AW-1:0] addr_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            addr_reg <= DACRB_ADDR_MAIN;
        end else if (i_load) begin
            addr_reg <= i_load_addr;
        end else if (i_advance) begin
            // past the last register the counter restarts at zero
            if (addr_reg >= DACRB_ADDR_LAST) begin
                addr_reg <= DACRB_ADDR_MAIN;
            end else begin
                addr_reg <= addr_reg + 5'h01;
            end
        end
    end

    assign o_addr = addr_reg;
endmodule // dacrb_addr_counter

/* File: dacrb_register_bank.sv */
// dac control register bank with its decoded control outputs
`timescale 1ns/1ps
// Function
// - mute release bit 0 mutes outputs, 1 allows normal operation.
// - standby request bit 1 puts device in standby.
// - stereo select picks multi-bit mono (0) or stereo (1) input.
// - rate mode picks 256-ratio (0) or 128-ratio (1) speed.
// - clock threshold select picks low (0) or high (1) clock levels.
// - clock-stop standby disable 0 enables automatic standby on stopped clock.
// - left and right route bits choose channel combination.
// - left and right phase invert bits invert their channel when set.
// - sound profile picks measurement (0) or sound quality (1).
// - power-down pin low returns all registers to zero.
// - address counter wraps from last register to zero.
module dacrb_register_bank
    import dacrb_pkg::*;
#(
    parameter int DATA_W = DACRB_DW,
    parameter int ADDR_W = DACRB_AW
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_down_pin_n,
    input wire logic i_start,
    input wire logic i_addr_valid,
    input wire logic [DACRB_AW-1:0] i_addr,
    input wire logic i_wr_valid,
    input wire logic [DACRB_DW-1:0] i_wr_data,
    input wire logic i_rd_req,
    output logic [DACRB_DW-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic [DACRB_AW-1:0] o_cur_addr,
    output logic o_mute,
    output logic o_standby_request,
    output logic o_stereo_select,
    output logic o_rate_mode_select,
    output logic o_clock_threshold_select,
    output logic o_clock_stop_standby_en,
    output logic o_left_route_select,
    output logic o_right_route_select,
    output logic o_left_phase_invert,
    output logic o_right_phase_invert,
    output logic o_sound_profile_select,
    output logic [DACRB_TUNE_LO_W:0] o_tuning_field,
    output logic o_factory_test_bit
);
    logic [DACRB_DW-1:0] main_control_reg;
    logic [DACRB_DW-1:0] output_control_reg;
    logic [DACRB_DW-1:0] tuning_test_control_reg;
    logic [DACRB_DW-1:0] rd_data_reg;
    logic rd_valid_reg;
    logic [DACRB_AW-1:0] addr;
    logic clear_regs;
    logic wr_en;
    logic rd_en;
    dacrb_acc_t state_reg;
    logic wr_main;
    logic wr_out;
    logic wr_tune;
    logic [DACRB_DW-1:0] rd_word;

    // the field map is fixed at one byte per register and a five-bit address
    if (DATA_W != DACRB_DW) begin : g_bad_data_w
        $error("register bank: DATA_W must match the byte-wide field map");
    end
    if (ADDR_W != DACRB_AW) begin : g_bad_addr_w
        $error("register bank: ADDR_W must match the five-bit register address");
    end
    // both halves of the tuning field must sit inside a register
    if (DACRB_TUNE_LO_LSB + DACRB_TUNE_LO_W > DATA_W) begin : g_bad_tune_lo
        $error("register bank: low tuning bits fall outside the register");
    end
    if (DACRB_TUNE_HI_BIT >= DATA_W) begin : g_bad_tune_hi
        $error("register bank: top tuning bit falls outside the register");
    end

    // register writes are refused while the power-down pin is low
    assign clear_regs = i_rst | ~i_power_down_pin_n;
    assign wr_en = i_wr_valid & i_power_down_pin_n;
    assign rd_en = i_rd_req & i_power_down_pin_n;

    // one address compare shared by the write strobes and the read mux
    function automatic logic addr_is(input logic [DACRB_AW-1:0] a,
        input logic [DACRB_AW-1:0] target);
        return a == target;
    endfunction

    function automatic logic [DACRB_DW-1:0] read_reg(input logic [DACRB_AW-1:0] a,
        input logic [DACRB_DW-1:0] r0, input logic [DACRB_DW-1:0] r1,
        input logic [DACRB_DW-1:0] r2);
        logic [DACRB_DW-1:0] v;
        v = DACRB_RST_VAL;
        if (addr_is(a, DACRB_ADDR_MAIN)) begin
            v = r0;
        end else if (addr_is(a, DACRB_ADDR_OUT)) begin
            v = r1;
        end else if (addr_is(a, DACRB_ADDR_TUNE)) begin
            v = r2;
        end
        return v;
    endfunction

    // unmapped addresses raise no strobe, so such writes simply vanish
    assign wr_main = wr_en & addr_is(addr, DACRB_ADDR_MAIN);
    assign wr_out = wr_en & addr_is(addr, DACRB_ADDR_OUT);
    assign wr_tune = wr_en & addr_is(addr, DACRB_ADDR_TUNE);
    assign rd_word = read_reg(addr, main_control_reg, output_control_reg,
        tuning_test_control_reg);

    // a load in the same cycle as a beat wins; that beat uses the old address
    dacrb_addr_counter u_addr (
        .i_clk(i_clk),
        .i_rst(clear_regs),
        .i_load(i_addr_valid & i_power_down_pin_n),
        .i_load_addr(i_addr),
        .i_advance(wr_en | rd_en),
        .o_addr(addr)
    );

    // access phase tracking: start, address loaded, data beats
    // kept for the port front end; no data path depends on the phase
    always_ff @(posedge i_clk) begin
        if (clear_regs) begin
            state_reg <= DACRB_ACC_IDLE;
        end else begin
            case (state_reg)
                DACRB_ACC_IDLE: begin
                    if (i_start) begin
                        state_reg <= DACRB_ACC_ADDR;
                    end
                end
                DACRB_ACC_ADDR: begin
                    if (i_addr_valid) begin
                        state_reg <= DACRB_ACC_DATA;
                    end
                end
                DACRB_ACC_DATA: begin
                    if (i_start) begin
                        state_reg <= DACRB_ACC_ADDR;
                    end
                end
                default: begin
                    state_reg <= DACRB_ACC_IDLE;
                end
            endcase
        end
    end

    // one process per register; the host keeps to the three registers
    always_ff @(posedge i_clk) begin
        if (clear_regs) begin
            main_control_reg <= DACRB_RST_VAL;
        end else if (wr_main) begin
            main_control_reg <= i_wr_data;
        end
    end

    // stored as written, fixed-zero bits included, so reads match
    always_ff @(posedge i_clk) begin
        if (clear_regs) begin
            output_control_reg <= DACRB_RST_VAL;
        end else if (wr_out) begin
            output_control_reg <= i_wr_data;
        end
    end

    // tuning bits are not forced; the host must load the pattern itself
    always_ff @(posedge i_clk) begin
        if (clear_regs) begin
            tuning_test_control_reg <= DACRB_RST_VAL;
        end else if (wr_tune) begin
            tuning_test_control_reg <= i_wr_data;
        end
    end

    // read data is the register at the counter, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (clear_regs) begin
            rd_data_reg <= DACRB_RST_VAL;
        end else if (rd_en) begin
            rd_data_reg <= rd_word;
        end
    end

    // a one-cycle strobe; the data itself holds until the next read
    always_ff @(posedge i_clk) begin
        if (clear_regs) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
        end
    end

    assign o_rd_data = rd_data_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_cur_addr = addr;

    // main_control decode; release and disable bits are inverted on the way out
    assign o_mute = ~main_control_reg[DACRB_MUTE_REL_BIT];
    assign o_standby_request = main_control_reg[DACRB_STANDBY_BIT];
    assign o_stereo_select = main_control_reg[DACRB_STEREO_BIT];
    assign o_rate_mode_select = main_control_reg[DACRB_RATE_BIT];
    assign o_clock_threshold_select = main_control_reg[DACRB_THRESH_BIT];
    assign o_clock_stop_standby_en = ~main_control_reg[DACRB_CSTOP_BIT];
    assign o_left_route_select = main_control_reg[DACRB_LSEL_BIT];
    assign o_right_route_select = main_control_reg[DACRB_RSEL_BIT];

    // output_control decode
    assign o_left_phase_invert = output_control_reg[DACRB_LEFT_INV_BIT];
    assign o_right_phase_invert = output_control_reg[DACRB_RIGHT_INV_BIT];
    assign o_sound_profile_select = output_control_reg[DACRB_PROFILE_BIT];

    // tuning_test_control decode
    // tuning field passed through as written; host is expected to load 0_0100
    assign o_tuning_field = {output_control_reg[DACRB_TUNE_HI_BIT],
        tuning_test_control_reg[DACRB_TUNE_LO_LSB +: DACRB_TUNE_LO_W]};
    assign o_factory_test_bit = tuning_test_control_reg[DACRB_TEST_BIT];
endmodule // dacrb_register_bank

/* File: dacrb_host_model.sv */
// host controller model driving the register port
`timescale 1ns/1ps
module dacrb_host_model
    import dacrb_pkg::*;
(
    input wire logic i_clk,
    output logic [2:0] o_req,
    output logic [DACRB_AW-1:0] o_addr,
    output logic [DACRB_DW-1:0] o_wr_data
);
    initial {o_req, o_addr, o_wr_data} = '0;
    // k is {load, write, read}; idle data flips so a stale byte never matches
    task automatic go(input logic [2:0] k, input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_req = k;
        o_addr = a;
        o_wr_data = k[1] ? d : ~o_wr_data;
    endtask
endmodule // dacrb_host_model

/* File: dacrb_register_bank_asserts.sv */
// port checker for the register bank
`timescale 1ns/1ps
module dacrb_register_bank_asserts
    import dacrb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_down_pin_n,
    input wire logic i_addr_valid,
    input wire logic i_wr_valid,
    input wire logic i_rd_req,
    input wire logic [DACRB_AW-1:0] i_addr,
    input wire logic [DACRB_AW-1:0] o_cur_addr,
    input wire logic [DACRB_DW-1:0] i_wr_data,
    input wire logic o_rd_valid,
    input wire logic o_mute,
    input wire logic o_standby_request,
    input wire logic o_left_phase_invert,
    input wire logic o_sound_profile_select
);
    logic w, r;
    assign w = i_wr_valid && i_power_down_pin_n;
    assign r = i_rd_req && i_power_down_pin_n;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_mute; w && o_cur_addr == 5'h0 |=> o_mute == !$past(i_wr_data[0]); endproperty
    a_mute: assert property (p_mute) else $error("mute");
    property p_standby;
        w && o_cur_addr == 5'h0 |=> o_standby_request == $past(i_wr_data[1]);
    endproperty
    a_standby: assert property (p_standby) else $error("standby");
    property p_inv; w && o_cur_addr == 5'h1 |=> o_left_phase_invert == $past(i_wr_data[1]); endproperty
    a_inv: assert property (p_inv) else $error("invert");
    property p_prof; w && o_cur_addr == 5'h1 |=> o_sound_profile_select == $past(i_wr_data[7]); endproperty
    a_prof: assert property (p_prof) else $error("profile");
    property p_pwrdn; !i_power_down_pin_n |=> o_mute && o_cur_addr == 5'h0; endproperty
    a_pwrdn: assert property (p_pwrdn) else $error("power down");
    property p_wrap; (w || r) && !i_addr_valid && o_cur_addr >= 5'h2 |=> o_cur_addr == 5'h0; endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");
    property p_load; i_addr_valid && i_power_down_pin_n |=> o_cur_addr == $past(i_addr); endproperty
    a_load: assert property (p_load) else $error("load");
    property p_rdv; r |=> o_rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("read valid");
    c_wrap: cover property (w && o_cur_addr == 5'h2);
    c_rd: cover property (r ##1 o_rd_valid);
    c_pwrdn: cover property (!i_power_down_pin_n);
endmodule // dacrb_register_bank_asserts
bind dacrb_register_bank dacrb_register_bank_asserts chk_i (.*);

/* File: dacrb_register_bank_bench.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
module dacrb_register_bank_bench
    import dacrb_pkg::*;
;
    logic i_clk = 1'b0, i_rst = 1'b1, i_power_down_pin_n = 1'b1, i_start = 1'b0;
    logic i_addr_valid, i_wr_valid, i_rd_req, o_rd_valid, o_mute, o_standby_request;
    logic o_stereo_select, o_rate_mode_select, o_clock_threshold_select, o_factory_test_bit;
    logic o_clock_stop_standby_en, o_left_route_select, o_right_route_select;
    logic o_left_phase_invert, o_right_phase_invert, o_sound_profile_select;
    logic [DACRB_AW-1:0] i_addr, o_cur_addr;
    logic [DACRB_TUNE_LO_W:0] o_tuning_field;
    logic [DACRB_DW-1:0] i_wr_data, o_rd_data, mv, ov, tv;
    int bad_count = 0, n_tests = 0;
    assign mv = {~o_clock_stop_standby_en, o_clock_threshold_select, o_rate_mode_select,
        o_stereo_select, o_left_route_select, o_right_route_select, o_standby_request, ~o_mute};
    assign ov = {o_sound_profile_select, o_tuning_field[4], 4'h0, o_left_phase_invert,
        o_right_phase_invert};
    assign tv = {o_tuning_field[3:0], 3'h0, o_factory_test_bit};
    always #2.5 i_clk = ~i_clk;
    dacrb_host_model host (.i_clk(i_clk), .o_req({i_addr_valid, i_wr_valid, i_rd_req}),
        .o_addr(i_addr), .o_wr_data(i_wr_data));
    dacrb_register_bank uut (.*);
    task automatic ck(input string s, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_main;
        for (int i = 0; i < 8; i++) begin
            host.go(3'h4, 5'h00, 8'h00);
            host.go(3'h2, 5'h00, 8'h01 << i);
            host.go(3'h0, 5'h00, 8'h00);
            ck("main", 8'h01 << i, mv);
        end
    endtask
    task automatic t_burst;
        logic [7:0] e[4] = '{8'h01, 8'h83, 8'h40, 8'h01};
        host.go(3'h4, 5'h01, 8'h00);
        host.go(3'h2, 5'h00, 8'h83);
        host.go(3'h2, 5'h00, 8'h40);
        host.go(3'h2, 5'h00, 8'h01);
        host.go(3'h4, 5'h00, 8'h00);
        ck("out", 8'h83, ov);
        ck("wrap", 8'h01, mv);
        for (int i = 0; i < 4; i++) begin
            host.go(3'h1, 5'h00, 8'h00);
            host.go(3'h0, 5'h00, 8'h00);
            ck("rd", e[i], o_rd_data);
            ck("rdv", 8'h01, {7'h00, o_rd_valid});
        end
    endtask
    task automatic t_pwrdn;
        host.go(3'h4, 5'h02, 8'h00);
        host.go(3'h2, 5'h00, 8'h40);
        host.go(3'h2, 5'h00, 8'h81);
        host.go(3'h0, 5'h00, 8'h00);
        ck("tune", 8'h40, tv);
        ck("wrap2", 8'h81, mv);
        i_power_down_pin_n = 1'b0;
        host.go(3'h2, 5'h00, 8'hff);
        host.go(3'h0, 5'h00, 8'h00);
        ck("pwrdn", 8'h00, mv | ov | tv);
        i_power_down_pin_n = 1'b1;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        #1 i_rst = 1'b0;
        ck("rst", 8'h00, mv | ov | tv);
        t_main();
        t_burst();
        t_pwrdn();
        stop_test();
    end
    // the run needs under 100 cycles
    initial begin
        #2000;
        bad_count++;
        stop_test();
    end
endmodule // dacrb_register_bank_bench
